// File: design/rec_mode_ctrl.sv
// Mode control of a remote-control encoder: code creation and packet send.
// Assumes raw pin inputs, one 250 MHz clock and a synchronous reset.
// Rate-select pins are taken as static while a packet goes out.
// Creation and sending exclude each other; a send request waits, a code-generation rise during a send is lost.
// Baud and lamp counts are worked out for the 250 MHz ref_clk.
// Summary of operation
// (R1) Send packets while transmit request is high.
// (R2) Shift packets out at rate-select baud.
// (R3) Lamp steady on while code-generation high.
// (R4) Lamp toggles after code-generation input drops.
// (R5) Record data inputs pressed while flashing.
// (R6) Second assertion stores key, lamp off, sleep.
// (R7) Radio enable high only while sending.
// (R8) Randomize code while high, latch on fall.
// (R9) Code word is twenty-four bits wide.
// (R10) Request low: finish packet, disable, sleep.
// (R11) Resample data inputs before every packet.
`timescale 1ns/100ps
`include "rec_regs.svh"
module rec_mode_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic send_request,
    input wire logic code_generate,
    input wire logic [1:0] rate_select,
    input wire logic [`REC_DATA_W-1:0] data_inputs,
    output logic serial_out,
    output logic status_lamp_output,
    output logic radio_enable_output,
    output rec_pkg::rec_key_s stored_key
);
    import rec_pkg::*;

    localparam logic [`REC_DIV_W-1:0] DIV0 =
        `REC_DIV_W'(`REC_CLK_HZ / `REC_BAUD_0 - 1);
    localparam logic [`REC_DIV_W-1:0] DIV1 =
        `REC_DIV_W'(`REC_CLK_HZ / `REC_BAUD_1 - 1);
    localparam logic [`REC_DIV_W-1:0] DIV2 =
        `REC_DIV_W'(`REC_CLK_HZ / `REC_BAUD_2 - 1);
    localparam logic [`REC_DIV_W-1:0] DIV3 =
        `REC_DIV_W'(`REC_CLK_HZ / `REC_BAUD_3 - 1);
    localparam logic [`REC_LAMP_W-1:0] LAMP_HALF =
        `REC_LAMP_W'(`REC_CLK_HZ / `REC_MS_PER_S * `REC_LAMP_HALF_MS - 1);
    localparam logic [`REC_BIT_W-1:0] LAST_BIT =
        `REC_BIT_W'(`REC_PKT_W - 1);
    localparam logic [`REC_SYNC_W-1:0] SYNC = `REC_SYNC_BYTE;

    ////////////////////////////////////////////////////////////////////////
    // Packet layout: sync byte, code word, permitted data, MSB first.
    function automatic logic [`REC_PKT_W-1:0] build_packet(
        input logic [`REC_CODE_W-1:0] code,
        input logic [`REC_DATA_W-1:0] masked
    );
        return {SYNC, code, masked};
    endfunction : build_packet

    rec_state_s st;
    rec_state_s next_st;
    logic send_s;
    logic create_s;
    logic [1:0] baud_s;
    logic [`REC_DATA_W-1:0] data_s;
    logic [`REC_DIV_W-1:0] div_top;
    logic bit_tick;
    logic lfsr_fb;
    logic [`REC_DATA_W-1:0] masked_data;
    logic [`REC_DATA_W-1:0] permit_seen;
    logic create_rise;
    logic create_start;
    logic send_start;
    logic lamp_wrap;
    logic last_bit;
    logic next_bit;
    logic [`REC_DIV_W-1:0] div_step;
    logic [`REC_PKT_W-1:0] fresh_packet;

    ////////////////////////////////////////////////////////////////////////
    // Synchronised views of the pins.
    assign send_s = st.send_sync[1];
    assign create_s = st.create_sync[1];
    assign baud_s = st.baud_sync[3:2];
    assign data_s = st.data_sync[2*`REC_DATA_W-1:`REC_DATA_W];

    ////////////////////////////////////////////////////////////////////////
    // Bit period from the static rate-select levels.
    always_comb begin
        if (baud_s == 2'h0) begin
            div_top = DIV0;
        end else if (baud_s == 2'h1) begin
            div_top = DIV1;
        end else if (baud_s == 2'h2) begin
            div_top = DIV2;
        end else begin
            div_top = DIV3;
        end
    end

    assign bit_tick = (st.div_cnt == div_top); // R2
    assign lfsr_fb = ^(st.lfsr & `REC_LFSR_TAPS);

    ////////////////////////////////////////////////////////////////////////
    // Per-button masking and permission capture.
    for (genvar i = 0; i < `REC_DATA_W; i++) begin : g_button
        assign masked_data[i] = data_s[i] & st.key.permit[i]; // R11
        assign permit_seen[i] = st.permit_acc[i] | data_s[i]; // R5
    end

    ////////////////////////////////////////////////////////////////////////
    // Events and values shared by the modes.
    assign create_rise = create_s && !st.create_prev;
    assign create_start = create_rise && st.boot_done; // R3
    assign send_start = send_s && st.boot_done; // R1
    assign lamp_wrap = (st.lamp_cnt == LAMP_HALF); // R4
    assign last_bit = (st.bit_cnt == LAST_BIT); // R10
    assign next_bit = st.shift[`REC_PKT_W-2]; // R2
    assign div_step = st.div_cnt + 1'b1;
    assign fresh_packet = build_packet(st.key.code_word, masked_data);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        next_st = st;
        next_st.send_sync = {st.send_sync[0], send_request};
        next_st.create_sync = {st.create_sync[0], code_generate};
        next_st.baud_sync = {st.baud_sync[1:0], rate_select};
        next_st.data_sync = {st.data_sync[`REC_DATA_W-1:0], data_inputs};
        next_st.create_prev = create_s;
        next_st.boot_done = 1'b1;
        // Modes run sleep, create, permit, sleep, or sleep, send, sleep.
        case (st.mode)
            REC_SLEEP: begin
                next_st.pins.status_lamp_output = 1'b0;
                next_st.pins.radio_enable_output = 1'b0;
                next_st.pins.serial_out = 1'b0;
                if (create_start) begin
                    next_st.mode = REC_CREATE;
                    next_st.pins.status_lamp_output = 1'b1; // R3
                end else if (send_start) begin
                    next_st.mode = REC_SEND; // R1
                    next_st.pins.radio_enable_output = 1'b1; // R7
                    next_st.shift = fresh_packet; // R11
                    next_st.pins.serial_out =
                        fresh_packet[`REC_PKT_W-1]; // R2
                    next_st.bit_cnt = '0;
                    next_st.div_cnt = '0;
                end
            end
            REC_CREATE: begin
                next_st.lfsr = {st.lfsr[`REC_CODE_W-2:0], lfsr_fb}; // R8
                next_st.pins.status_lamp_output = 1'b1; // R3
                if (!create_s) begin
                    next_st.mode = REC_PERMIT;
                    next_st.permit_acc = '0;
                    next_st.lamp_cnt = '0;
                    next_st.pins.status_lamp_output = 1'b0; // R4
                end
            end
            REC_PERMIT: begin
                next_st.permit_acc = permit_seen; // R5
                if (lamp_wrap) begin
                    next_st.lamp_cnt = '0;
                    next_st.pins.status_lamp_output =
                        !st.pins.status_lamp_output; // R4
                end else begin
                    next_st.lamp_cnt = st.lamp_cnt + 1'b1;
                end
                if (create_rise) begin
                    next_st.key.code_word = st.lfsr; // R9
                    next_st.key.permit = permit_seen; // R6
                    next_st.pins.status_lamp_output = 1'b0; // R6
                    next_st.mode = REC_SLEEP; // R6
                end
            end
            REC_SEND: begin
                next_st.pins.radio_enable_output = 1'b1; // R7
                if (bit_tick) begin
                    next_st.div_cnt = '0;
                    if (last_bit) begin
                        next_st.bit_cnt = '0;
                        if (send_s) begin
                            next_st.shift = fresh_packet; // R11
                            next_st.pins.serial_out =
                                fresh_packet[`REC_PKT_W-1]; // R2
                        end else begin
                            next_st.mode = REC_SLEEP; // R10
                            next_st.pins.radio_enable_output = 1'b0; // R10
                            next_st.pins.serial_out = 1'b0;
                        end
                    end else begin
                        next_st.bit_cnt = st.bit_cnt + 1'b1;
                        next_st.shift = {st.shift[`REC_PKT_W-2:0], 1'b0};
                        next_st.pins.serial_out = next_bit; // R2
                    end
                end else begin
                    next_st.div_cnt = div_step;
                end
            end
            default: begin
                next_st.mode = REC_SLEEP;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register with clock enable.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.mode <= REC_SLEEP;
            st.lfsr <= `REC_LFSR_SEED;
            st.create_prev <= 1'b1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins and key straight from the state register.
    assign serial_out = st.pins.serial_out;
    assign status_lamp_output = st.pins.status_lamp_output;
    assign radio_enable_output = st.pins.radio_enable_output;
    assign stored_key = st.key;
endmodule : rec_mode_ctrl

// File: design/rec_regs.svh
// Timing and field constants for the remote encoder mode control.
// Assumes a 250 MHz ref_clk and is included by bare name.
`ifndef REC_REGS_SVH
`define REC_REGS_SVH
`define REC_CLK_HZ 250000000
`define REC_BAUD_0 2400
`define REC_BAUD_1 4800
`define REC_BAUD_2 9600
`define REC_BAUD_3 28800
`define REC_LAMP_HALF_MS 250
`define REC_MS_PER_S 1000
`define REC_CODE_W 24
`define REC_DATA_W 8
`define REC_SYNC_W 8
`define REC_SYNC_BYTE 8'hA5
`define REC_PKT_W 40
`define REC_LFSR_SEED 24'h5A3C96
`define REC_LFSR_TAPS 24'hE10000
`define REC_DIV_W 18
`define REC_LAMP_W 26
`define REC_BIT_W 6
`endif

// File: design/rec_pkg.sv
// Types for the remote encoder mode control.
// Assumes rec_regs.svh is reachable on the include path.
`include "rec_regs.svh"
package rec_pkg;
    typedef enum logic [2:0] {
        REC_SLEEP,
        REC_CREATE,
        REC_PERMIT,
        REC_SEND
    } rec_mode_e;

    typedef struct packed {
        logic [`REC_CODE_W-1:0] code_word;
        logic [`REC_DATA_W-1:0] permit;
    } rec_key_s;

    typedef struct packed {
        logic serial_out;
        logic status_lamp_output;
        logic radio_enable_output;
    } rec_pins_s;

    typedef struct packed {
        logic [1:0] send_sync;
        logic [1:0] create_sync;
        logic [3:0] baud_sync;
        logic [2*`REC_DATA_W-1:0] data_sync;
        logic create_prev;
        rec_mode_e mode;
        logic [`REC_CODE_W-1:0] lfsr;
        rec_key_s key;
        logic [`REC_DATA_W-1:0] permit_acc;
        logic [`REC_PKT_W-1:0] shift;
        logic [`REC_BIT_W-1:0] bit_cnt;
        logic [`REC_DIV_W-1:0] div_cnt;
        logic [`REC_LAMP_W-1:0] lamp_cnt;
        logic boot_done;
        rec_pins_s pins;
    } rec_state_s;
endpackage : rec_pkg

// File: sim/rec_mode_ctrl_checker.sv
// Port-level assertions for the encoder mode control.
// Assumes it is bound to rec_mode_ctrl and sees only its ports.
`timescale 1ns/100ps
module rec_mode_ctrl_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic send_request,
    input wire logic code_generate,
    input wire logic serial_out,
    input wire logic status_lamp_output,
    input wire logic radio_enable_output
);
    logic gen_prev;
    logic in_create;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !clk_en);
    // Tracks create phase: odd count of accepted rises.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gen_prev <= 1'b1;
            in_create <= 1'b0;
        end else if (clk_en) begin
            gen_prev <= code_generate;
            if (code_generate && !gen_prev && !radio_enable_output) begin
                in_create <= !in_create;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_lamp_on;
        (in_create && code_generate)[*5] |-> status_lamp_output;
    endproperty
    a_lamp_on: assert property (p_lamp_on)
        else $error("lamp not on while creating");
    property p_lamp_fall;
        $fell(code_generate) && in_create |-> ##5 !status_lamp_output;
    endproperty
    a_lamp_fall: assert property (p_lamp_fall)
        else $error("flash did not start off");
    property p_store_off;
        $rose(code_generate) && in_create && !radio_enable_output
            |-> ##5 !status_lamp_output [*3];
    endproperty
    a_store_off: assert property (p_store_off)
        else $error("lamp not off after store");
    property p_first_bit;
        $rose(radio_enable_output) |-> serial_out;
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first bit not one");
    property p_radio_cause;
        $rose(radio_enable_output) |-> $past(send_request, 3);
    endproperty
    a_radio_cause: assert property (p_radio_cause)
        else $error("radio enabled without request");
    property p_send_start;
        $rose(send_request) && !radio_enable_output && !in_create
            ##1 send_request [*3] |-> radio_enable_output;
    endproperty
    a_send_start: assert property (p_send_start)
        else $error("send not started");
    property p_radio_fall;
        $fell(radio_enable_output) |-> !serial_out && !$past(send_request, 3);
    endproperty
    a_radio_fall: assert property (p_radio_fall)
        else $error("radio dropped while requested");
    property p_idle_line;
        !radio_enable_output |-> !serial_out;
    endproperty
    a_idle_line: assert property (p_idle_line)
        else $error("serial active while radio off");
endmodule : rec_mode_ctrl_checker
bind rec_mode_ctrl rec_mode_ctrl_checker rec_mode_ctrl_checker_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .send_request(send_request),
    .code_generate(code_generate),
    .serial_out(serial_out),
    .status_lamp_output(status_lamp_output),
    .radio_enable_output(radio_enable_output)
);

// File: sim/rec_radio_rx.sv
// Behavioural radio receiver: samples the serial line mid-bit.
// Assumes a fixed bit period in ref_clk cycles.
`timescale 1ns/100ps
module rec_radio_rx #(parameter int BIT_CYC = 8680) (
    input wire logic ref_clk,
    input wire logic serial_in,
    input wire logic radio_on,
    output logic [7:0] rx_byte,
    output logic [7:0] rx_cnt
);
    int cyc;
    always_ff @(posedge ref_clk) begin
        if (!radio_on) begin
            cyc <= 0;
            rx_cnt <= 8'h00;
            rx_byte <= 8'h00;
        end else begin
            cyc <= (cyc == BIT_CYC - 1) ? 0 : cyc + 1;
            if (cyc == BIT_CYC / 2) begin
                rx_byte <= {rx_byte[6:0], serial_in};
                rx_cnt <= rx_cnt + 8'h01;
            end
        end
    end
endmodule : rec_radio_rx

// File: sim/rec_mode_ctrl_test.sv
// Self-checking bench for the encoder mode control.
// Assumes rec_pkg and rec_regs.svh are compiled first.
`timescale 1ns/100ps
`include "rec_regs.svh"
module rec_mode_ctrl_test;
    import rec_pkg::*;
    localparam int BIT_CYC = `REC_CLK_HZ / `REC_BAUD_3;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic send_request = 1'b0;
    logic code_generate = 1'b0;
    logic [7:0] data_inputs = 8'h00;
    logic [7:0] perm_exp;
    logic [15:0] lfsr = 16'hCEA9;
    logic serial_out, status_lamp_output, radio_enable_output;
    logic [7:0] rx_byte, rx_cnt;
    rec_key_s stored_key;
    int num_errors = 0;
    int cmp_count = 0;
    always #2 ref_clk = ~ref_clk;
    rec_mode_ctrl rec_mode_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
        .clk_en(1'b1), .send_request(send_request),
        .code_generate(code_generate), .rate_select(2'h3),
        .data_inputs(data_inputs), .serial_out(serial_out),
        .status_lamp_output(status_lamp_output),
        .radio_enable_output(radio_enable_output), .stored_key(stored_key));
    rec_radio_rx #(.BIT_CYC(BIT_CYC)) rec_radio_rx_inst (.ref_clk(ref_clk),
        .serial_in(serial_out), .radio_on(radio_enable_output),
        .rx_byte(rx_byte), .rx_cnt(rx_cnt));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic check(logic ok, string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task automatic print_verdict;
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        #(4 * 90000);
        num_errors++;
        print_verdict();
    end
    initial begin
        tick(5);
        rst <= 1'b0;
        tick(3);
        code_generate <= 1'b1;
        lfsr = lfsr_next(lfsr);
        tick(20 + lfsr[5:0]);
        check(status_lamp_output === 1'b1, "lamp not on");
        check(radio_enable_output === 1'b0, "radio on in create");
        code_generate <= 1'b0;
        tick(6);
        check(status_lamp_output === 1'b0, "flash not off");
        perm_exp = 8'h00;
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            data_inputs <= lfsr[7:0];
            perm_exp = perm_exp | lfsr[7:0];
            tick(6);
        end
        data_inputs <= 8'h00;
        tick(4);
        code_generate <= 1'b1;
        tick(8);
        check(stored_key.permit === perm_exp, "permit set");
        check(status_lamp_output === 1'b0, "lamp on after store");
        check(stored_key.code_word !== `REC_LFSR_SEED, "code fixed");
        code_generate <= 1'b0;
        tick(6);
        data_inputs <= lfsr[15:8];
        send_request <= 1'b1;
        tick(4);
        check(radio_enable_output === 1'b1, "radio not on");
        tick(8 * BIT_CYC);
        check(rx_byte === `REC_SYNC_BYTE, "sync byte");
        check(rx_cnt === 8'h08, "bit count");
        send_request <= 1'b0;
        tick(20);
        check(radio_enable_output === 1'b1, "packet cut short");
        print_verdict();
    end
endmodule : rec_mode_ctrl_test
